// *** irq_mask_port_select_pkg.sv ***
// Package for the global interrupt mask and per-port sync/clock selection bank.
// Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
package irq_mask_port_select_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;   // Sticky interrupt status, clear on read
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;   // global_interrupt_mask
    localparam logic [7:0]  OFS_SEL_LOW     = 8'h18;   // port_sync_clock_select_low, ports 1..4
    localparam logic [7:0]  OFS_SEL_HIGH    = 8'h1C;   // port_sync_clock_select_high, ports 5..8
    localparam logic [7:0]  OFS_MODE_CTRL   = 8'h24;   // Holds internal_external_mode_bit

    // Bus geometry
    localparam int          APB_ADDR_W      = 8;
    localparam int          APB_DATA_W      = 32;

    // Interrupt field layout
    localparam int          PKT_IRQ_BIT     = 24;      // Packet core request
    localparam int          LINE_IRQ_LSB    = 16;      // Line interfaces 1..8 at 16..23
    localparam int          BERT_IRQ_LSB    = 8;       // Bit error testers 1..8 at 8..15
    localparam int          FRM_IRQ_LSB     = 0;       // Framers 1..8 at 0..7
    localparam logic [31:0] IRQ_USED_MASK   = 32'h01FF_FFFF;
    localparam logic [31:0] IRQ_MASK_RST    = 32'h0000_0000;

    // Per-port selection byte
    localparam int          PORT_BYTE_W     = 8;
    localparam int          SYNC_SEL_W      = 3;
    localparam int          CLK_SEL_W       = 5;
    localparam int          SYNC_SEL_LSB    = 5;       // Sync field sits above the clock field
    localparam int          CLK_SEL_LSB     = 0;
    localparam logic [31:0] SEL_LOW_RST     = 32'h6342_2100;   // Port n holds n-1 in both fields
    localparam logic [31:0] SEL_HIGH_RST    = 32'hE7C6_A584;

    // Clock selection code groups (top two bits of the clock field)
    localparam logic [1:0]  CLK_GRP_LINE    = 2'h0;    // Line recovered clocks
    localparam logic [1:0]  CLK_GRP_ADAPT   = 2'h1;    // Adaptive recovered clocks
    localparam logic [1:0]  CLK_GRP_EXT     = 2'h2;    // External clock pins
    localparam logic [1:0]  CLK_GRP_SYNTH   = 2'h3;    // Synthesizer clocks

    // Mode control
    localparam int          MODE_BIT        = 0;
    localparam logic        MODE_EXTERNAL   = 1'b1;
    localparam logic        MODE_RST        = 1'b0;    // Internal mode after reset

endpackage

// *** port_source_mux.sv ***
// One port's frame sync and reference clock selector with registered outputs.
// Assumes the clock-domain sources arrive already synchronised to core_clk.
`timescale 1ns/10ps
module port_source_mux
    import irq_mask_port_select_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic [SYNC_SEL_W-1:0] sync_sel,
    input  wire logic [CLK_SEL_W-1:0]  clk_sel,
    input  wire logic [NUM_SRC-1:0]    formatter_sync,
    input  wire logic [NUM_SRC-1:0]    line_clk,
    input  wire logic [NUM_SRC-1:0]    adapt_clk,
    input  wire logic [NUM_SRC-1:0]    ext_clk,
    input  wire logic                  e1_clk,
    input  wire logic                  t1_clk,
    output logic                       sync_ref,
    output logic                       ref_clk
);

    // The code space gives three index bits per source group; other counts are refused at elaboration
    if (NUM_SRC != 8) begin : g_bad_src_count
        $error("port_source_mux supports exactly eight sources per group");
    end

    logic       sync_ref_ff;     // Registered sync reference
    logic       ref_clk_ff;      // Registered reference clock
    logic       nxt_sync_ref;
    logic       nxt_ref_clk;
    logic [2:0] src_idx;         // Index inside a clock group

    // Selection logic
    always_comb begin
        src_idx      = clk_sel[2:0];
        nxt_sync_ref = formatter_sync[sync_sel];
        case (clk_sel[CLK_SEL_W-1 -: 2])
            CLK_GRP_LINE: begin
                nxt_ref_clk = line_clk[src_idx];
            end
            CLK_GRP_ADAPT: begin
                // Contiguous codes: low three bits pick the port
                nxt_ref_clk = adapt_clk[src_idx];
            end
            CLK_GRP_EXT: begin
                nxt_ref_clk = ext_clk[src_idx];
            end
            default: begin
                // Bits 2..1 are don't-care, bit 0 picks the rate
                nxt_ref_clk = clk_sel[0] ? t1_clk : e1_clk;
            end
        endcase
    end

    // Output registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_ref_ff <= 1'b0;
            ref_clk_ff  <= 1'b0;
        end else begin
            sync_ref_ff <= nxt_sync_ref;
            ref_clk_ff  <= nxt_ref_clk;
        end
    end

    assign sync_ref = sync_ref_ff;
    assign ref_clk  = ref_clk_ff;

endmodule

// *** irq_mask_port_select.sv ***
// Global interrupt mask bank and per-port sync/clock selection registers on APB.
// Assumes interrupt requests and formatter syncs come from core_clk logic, while the
// line recovered, external and synthesizer clocks are asynchronous and sampled here.
//
// What this block does
// - Mask bit 24 gates packet-core request
// - Bits 23..16 gate line interfaces 8..1
// - Bits 15..8 gate bit error testers 8..1
// - Bits 7..0 gate framers 8..1
// - Mask resets zero; one enables source
// - External mode ignores all selection fields
// - Sync codes 0..7 pick formatter 1..8
// - Clock codes 0..7 pick line clocks
// - Codes 01000..01111 pick adaptive clocks
// - Codes 10000..10111 pick external pins
// - 11XX0 picks E1 clock, 11XX1 T1
// - One byte per port, sync above clock
// - Port n fields reset to n-1
// - Forward request only when mask enabled
`timescale 1ns/10ps
module irq_mask_port_select
    import irq_mask_port_select_pkg::*;
#(
    parameter int NUM_PORTS = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [APB_DATA_W-1:0] pwdata,
    output logic      [APB_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Interrupt sources, levels on core_clk
    input  wire logic                  packet_core_irq_req,
    input  wire logic [NUM_PORTS-1:0]  line_iface_irq_req,
    input  wire logic [NUM_PORTS-1:0]  bit_error_tester_irq_req,
    input  wire logic [NUM_PORTS-1:0]  framer_irq_req,
    output logic                       irq,
    // Selection sources
    input  wire logic [NUM_PORTS-1:0]  formatter_transmit_sync,
    input  wire logic [NUM_PORTS-1:0]  line_recovered_clock,
    input  wire logic [NUM_PORTS-1:0]  adaptive_recovered_clock,
    input  wire logic [NUM_PORTS-1:0]  external_clock_input,
    input  wire logic                  e1_rate_synth_clock,
    input  wire logic                  t1_rate_synth_clock,
    // Per-port selected references
    output logic      [NUM_PORTS-1:0]  port_sync_ref,
    output logic      [NUM_PORTS-1:0]  port_ref_clk
);

    // Register layout is fixed at eight ports, four per word; other counts are refused at elaboration
    if (NUM_PORTS != 8) begin : g_bad_port_count
        $error("irq_mask_port_select supports exactly eight ports");
    end

    localparam int ASYNC_W = 3 * NUM_PORTS + 2;   // Three port groups plus E1 and T1; async_raw fills only line, external, E1 and T1, top 8 bits zero

    // Register state
    logic [31:0]          irq_mask_ff;     // global_interrupt_mask
    logic [31:0]          irq_status_ff;   // Sticky status
    logic [31:0]          sel_low_ff;      // port_sync_clock_select_low
    logic [31:0]          sel_high_ff;     // port_sync_clock_select_high
    logic                 mode_ff;         // internal_external_mode_bit
    logic [31:0]          prdata_ff;       // Read data caught in the setup cycle
    logic                 irq_ff;          // Registered interrupt line
    logic [31:0]          nxt_irq_mask;
    logic [31:0]          nxt_irq_status;
    logic [31:0]          nxt_sel_low;
    logic [31:0]          nxt_sel_high;
    logic                 nxt_mode;
    logic [31:0]          nxt_prdata;
    logic                 nxt_irq;

    // Synchroniser state
    logic [ASYNC_W-1:0]   async_raw;       // Raw asynchronous inputs
    logic [ASYNC_W-1:0]   meta_ff;         // First stage, read only by sync_ff
    logic [ASYNC_W-1:0]   sync_ff;         // Second stage, safe to use

    // Decode helpers
    logic                 addr_hit;        // Mapped word address
    logic                 setup_rd;        // Read setup cycle
    logic                 access_wr;       // Completing write
    logic                 access_rd;       // Completing read of the status register
    logic [31:0]          rd_mux;          // Read value of the addressed register
    logic [31:0]          irq_src;         // Source requests in status layout
    logic [63:0]          sel_all;         // Both selection words, port 1 lowest
    logic [63:0]          sel_rst_all;     // Reset image, each port's own sources

    // Address decode and phase qualifiers
    always_comb begin
        addr_hit  = (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK) ||
                    (paddr == OFS_SEL_LOW) || (paddr == OFS_SEL_HIGH) ||
                    (paddr == OFS_MODE_CTRL);
        setup_rd  = psel && !penable && !pwrite;
        access_wr = psel && penable && pwrite && addr_hit;
        access_rd = psel && penable && !pwrite && (paddr == OFS_IRQ_STATUS);
        case (paddr)
            OFS_IRQ_STATUS: rd_mux = irq_status_ff;
            OFS_IRQ_MASK:   rd_mux = irq_mask_ff;
            OFS_SEL_LOW:    rd_mux = sel_low_ff;
            OFS_SEL_HIGH:   rd_mux = sel_high_ff;
            OFS_MODE_CTRL:  rd_mux = {31'h0000_0000, mode_ff};
            default:        rd_mux = 32'h0000_0000;   // Unmapped reads return zero
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata  = prdata_ff;
    assign irq     = irq_ff;

    // Gather sources into the status layout
    always_comb begin
        irq_src                                  = 32'h0000_0000;
        irq_src[PKT_IRQ_BIT]                     = packet_core_irq_req;
        irq_src[LINE_IRQ_LSB +: NUM_PORTS]       = line_iface_irq_req;
        irq_src[BERT_IRQ_LSB +: NUM_PORTS]       = bit_error_tester_irq_req;
        irq_src[FRM_IRQ_LSB +: NUM_PORTS]        = framer_irq_req;
    end

    // Next register values
    always_comb begin
        nxt_irq_mask = irq_mask_ff;
        nxt_sel_low  = sel_low_ff;
        nxt_sel_high = sel_high_ff;
        nxt_mode     = mode_ff;
        if (access_wr) begin
            case (paddr)
                OFS_IRQ_MASK: begin
                    // Unused high bits are never stored, so they read zero
                    nxt_irq_mask = pwdata & IRQ_USED_MASK;
                end
                OFS_SEL_LOW: begin
                    nxt_sel_low = pwdata;
                end
                OFS_SEL_HIGH: begin
                    nxt_sel_high = pwdata;
                end
                OFS_MODE_CTRL: begin
                    nxt_mode = pwdata[MODE_BIT];
                end
                default: begin
                    // Status is read-only; writes are dropped
                end
            endcase
        end
        // Read data is caught at setup so that clear-on-read only clears what was seen
        nxt_prdata = setup_rd ? rd_mux : prdata_ff;
        // A request present in the clearing cycle survives: set wins over clear
        nxt_irq_status = ((irq_status_ff & ~(access_rd ? prdata_ff : 32'h0000_0000)) | irq_src)
                         & IRQ_USED_MASK;
        nxt_irq = |(irq_status_ff & irq_mask_ff);
    end

    // Register updates
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask_ff   <= IRQ_MASK_RST;
            irq_status_ff <= 32'h0000_0000;
            sel_low_ff    <= SEL_LOW_RST;
            sel_high_ff   <= SEL_HIGH_RST;
            mode_ff       <= MODE_RST;
            prdata_ff     <= 32'h0000_0000;
            irq_ff        <= 1'b0;
        end else begin
            irq_mask_ff   <= nxt_irq_mask;
            irq_status_ff <= nxt_irq_status;
            sel_low_ff    <= nxt_sel_low;
            sel_high_ff   <= nxt_sel_high;
            mode_ff       <= nxt_mode;
            prdata_ff     <= nxt_prdata;
            irq_ff        <= nxt_irq;
        end
    end

    // Two-stage synchroniser for the asynchronous clock sources
    assign async_raw = {t1_rate_synth_clock, e1_rate_synth_clock, external_clock_input, line_recovered_clock};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_raw;
            sync_ff <= meta_ff;
        end
    end

    // Selection words; external mode falls back to each port's own sources
    assign sel_all     = {sel_high_ff, sel_low_ff};
    assign sel_rst_all = {SEL_HIGH_RST, SEL_LOW_RST};

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [PORT_BYTE_W-1:0] eff_byte;   // Selection byte in force

            // Fields are ignored outside internal mode
            assign eff_byte = (mode_ff == MODE_EXTERNAL) ? sel_rst_all[p*PORT_BYTE_W +: PORT_BYTE_W]
                                                         : sel_all[p*PORT_BYTE_W +: PORT_BYTE_W];

            port_source_mux #(
                .NUM_SRC (NUM_PORTS)
            ) u_mux (
                .core_clk       (core_clk),
                .rst            (rst),
                .sync_sel       (eff_byte[SYNC_SEL_LSB +: SYNC_SEL_W]),
                .clk_sel        (eff_byte[CLK_SEL_LSB +: CLK_SEL_W]),
                .formatter_sync (formatter_transmit_sync),
                .line_clk       (sync_ff[0 +: NUM_PORTS]),
                .adapt_clk      (adaptive_recovered_clock),
                .ext_clk        (sync_ff[NUM_PORTS +: NUM_PORTS]),
                .e1_clk         (sync_ff[2*NUM_PORTS]),
                .t1_clk         (sync_ff[2*NUM_PORTS+1]),
                .sync_ref       (port_sync_ref[p]),
                .ref_clk        (port_ref_clk[p])
            );
        end
    endgenerate

    // Checks on the mask, status and selection paths
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_mask_reset;
        $past(rst) && !rst |-> (irq_mask_ff == 32'h0000_0000) && !irq_ff;
    endproperty
    a_mask_reset: assert property (disable iff (1'b0) p_mask_reset) else $error("mask not zero after reset");

    property p_unused_zero;
        irq_mask_ff[31:25] == 7'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused mask bits set");

    property p_pkt_gate;
        irq_status_ff[PKT_IRQ_BIT] && irq_mask_ff[PKT_IRQ_BIT] |=> irq;
    endproperty
    a_pkt_gate: assert property (p_pkt_gate) else $error("enabled packet request not forwarded");

    property p_line_gate;
        |(irq_status_ff[23:16] & irq_mask_ff[23:16]) |=> irq;
    endproperty
    a_line_gate: assert property (p_line_gate) else $error("enabled line request not forwarded");

    property p_bert_gate;
        |(irq_status_ff[15:8] & irq_mask_ff[15:8]) |=> irq;
    endproperty
    a_bert_gate: assert property (p_bert_gate) else $error("enabled tester request not forwarded");

    property p_frm_gate;
        |(irq_status_ff[7:0] & irq_mask_ff[7:0]) |=> irq;
    endproperty
    a_frm_gate: assert property (p_frm_gate) else $error("enabled framer request not forwarded");

    property p_masked_quiet;
        ((irq_status_ff & irq_mask_ff) == 32'h0000_0000) |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked request reached irq");

    property p_ext_mode;
        (mode_ff == MODE_EXTERNAL) |=> port_sync_ref[1] == $past(formatter_transmit_sync[1]);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("selection used in external mode");

    property p_sync_sel;
        (mode_ff != MODE_EXTERNAL) |=> port_sync_ref[0] == $past(formatter_transmit_sync[sel_low_ff[7:5]]);
    endproperty
    a_sync_sel: assert property (p_sync_sel) else $error("port 1 sync reference wrong");

    property p_clk_line;
        (mode_ff != MODE_EXTERNAL) && (sel_low_ff[4:3] == CLK_GRP_LINE)
            |=> port_ref_clk[0] == $past(sync_ff[sel_low_ff[2:0]]);
    endproperty
    a_clk_line: assert property (p_clk_line) else $error("port 1 line clock wrong");

    property p_clk_synth;
        (mode_ff != MODE_EXTERNAL) && (sel_low_ff[4:3] == CLK_GRP_SYNTH)
            |=> port_ref_clk[0] == $past(sel_low_ff[0] ? sync_ff[17] : sync_ff[16]);
    endproperty
    a_clk_synth: assert property (p_clk_synth) else $error("port 1 synthesizer clock wrong");

    // Adaptive clocks are same-clock signals, so they skip the synchroniser
    property p_clk_adapt;
        (mode_ff != MODE_EXTERNAL) && (sel_low_ff[4:3] == CLK_GRP_ADAPT)
            |=> port_ref_clk[0] == $past(adaptive_recovered_clock[sel_low_ff[2:0]]);
    endproperty
    a_clk_adapt: assert property (p_clk_adapt) else $error("port 1 adaptive clock wrong");

    // External pins sit just above the line clocks in the synchroniser
    property p_clk_ext;
        (mode_ff != MODE_EXTERNAL) && (sel_low_ff[4:3] == CLK_GRP_EXT)
            |=> port_ref_clk[0] == $past(sync_ff[NUM_PORTS + sel_low_ff[2:0]]);
    endproperty
    a_clk_ext: assert property (p_clk_ext) else $error("port 1 external clock wrong");

    property p_sel_reset;
        $past(rst) && !rst |-> (sel_high_ff[31:24] == 8'hE7) && (sel_low_ff[7:0] == 8'h00);
    endproperty
    a_sel_reset: assert property (disable iff (1'b0) p_sel_reset) else $error("selection reset wrong");

    c_irq_rise: cover property ($rose(irq));
    c_read_clear: cover property (access_rd && (prdata_ff != 32'h0000_0000));
    c_ext_mode: cover property ($rose(mode_ff));

endmodule

// *** irq_mask_port_select_test.sv ***
// Self-checking bench for the interrupt mask bank and per-port source selection.
// Assumes the design package and the design files are compiled ahead of this file.
`timescale 1ns/10ps
module irq_mask_port_select_test
    import irq_mask_port_select_pkg::*;
;
    logic                  core_clk;                  // 250 MHz bench clock
    logic                  rst;                       // Synchronous reset, active high
    logic                  psel, penable, pwrite;     // APB request
    logic [APB_ADDR_W-1:0] paddr;                     // APB byte address
    logic [APB_DATA_W-1:0] pwdata, prdata;            // APB data
    logic                  pready, pslverr;           // APB answer
    logic                  pkt_req, e1_clk, t1_clk;   // Single-bit sources
    logic [7:0]            line_req, bert_req, frm_req;
    logic [7:0]            fmt_sync, line_clk, adapt_clk, ext_clk;
    logic                  irq;                       // Level interrupt out
    logic [7:0]            sync_ref, ref_clk;         // Per-port selected references
    logic [31:0]           rd;                        // Last read word
    logic                  er;                        // Last error flag
    int                    err_count, check_count;    // Mismatch and compare tallies
    // One ordinary case: mask word, source bit raised, interrupt level expected
    typedef struct { logic [31:0] mask; int src; logic exp; } irq_row_t;
    irq_row_t rows [11] = '{
        '{32'h0100_0000, 24, 1'b1}, '{32'h0000_0000, 24, 1'b0}, '{32'h00FF_FFFF, 24, 1'b0},
        '{32'h0080_0000, 23, 1'b1}, '{32'h0001_0000, 16, 1'b1}, '{32'h0080_0000, 16, 1'b0},
        '{32'h0000_8000, 15, 1'b1}, '{32'h0000_0100, 8, 1'b1}, '{32'h0000_0080, 7, 1'b1},
        '{32'h0000_0001, 0, 1'b1}, '{32'h01FF_FFFE, 0, 1'b0}};

    irq_mask_port_select DUT (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .packet_core_irq_req(pkt_req), .line_iface_irq_req(line_req),
        .bit_error_tester_irq_req(bert_req), .framer_irq_req(frm_req), .irq(irq),
        .formatter_transmit_sync(fmt_sync), .line_recovered_clock(line_clk),
        .adaptive_recovered_clock(adapt_clk), .external_clock_input(ext_clk),
        .e1_rate_synth_clock(e1_clk), .t1_rate_synth_clock(t1_clk),
        .port_sync_ref(sync_ref), .port_ref_clk(ref_clk));

    // Free-running clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Compare one value and tally; four-state equality so X never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; waits on pready rather than assuming zero wait states
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Interrupt requests as one 25-bit image laid out like the mask
    task automatic drive_req(input logic [24:0] v);
        pkt_req <= v[24]; line_req <= v[23:16]; bert_req <= v[15:8]; frm_req <= v[7:0];
    endtask

    // Chosen clock and sync sources get v, every other source the inverse
    task automatic drive_src(input logic [1:0] g, input logic [2:0] k, input logic [2:0] s,
                             input logic v);
        logic [7:0] l, ad, ex, f;
        logic       e1, t1;
        l = {8{~v}}; ad = l; ex = l; f = l; e1 = ~v; t1 = ~v;
        case (g)
            CLK_GRP_LINE:  l[k] = v;
            CLK_GRP_ADAPT: ad[k] = v;
            CLK_GRP_EXT:   ex[k] = v;
            default: begin
                if (k[0]) t1 = v;      // Odd code picks the T1-rate clock
                else e1 = v;
            end
        endcase
        f[s] = v;
        line_clk <= l; adapt_clk <= ad; ext_clk <= ex; fmt_sync <= f; e1_clk <= e1; t1_clk <= t1;
    endtask

    // Report counts and verdict, then end the run
    task automatic stop_test();
        $display("checks made %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs about seven hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        int         p;
        logic [4:0] code;
        logic [2:0] s;
        err_count = 0; check_count = 0;
        rst <= 1'b1; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
        paddr <= 8'h00; pwdata <= 32'h0000_0000;
        drive_req(25'h0);
        drive_src(2'h0, 3'h0, 3'h0, 1'b0);
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        // Table of mask cases; masked sources still latch in status
        foreach (rows[i]) begin
            apb(1'b1, OFS_IRQ_MASK, rows[i].mask);
            drive_req(25'h1 << rows[i].src);
            repeat (3) @(posedge core_clk);
            chk(irq, rows[i].exp, "irq level");
            drive_req(25'h0);
            apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
            chk(rd, 32'h1 << rows[i].src, "status bit");
            apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
            chk(rd, 32'h0000_0000, "status cleared");
            repeat (2) @(posedge core_clk);
            chk(irq, 1'b0, "irq after clear");
        end
        $display("test irq rows done");
        // Software keeps the reserved bits zero; every used bit stores and reads back
        apb(1'b1, OFS_IRQ_MASK, 32'h01FF_FFFF);
        apb(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
        chk(rd, 32'h01FF_FFFF, "mask used bits");
        chk(er, 1'b0, "mapped read error");
        // Second reset in mid-run restores every register
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "mask reset");
        apb(1'b0, OFS_SEL_LOW, 32'h0000_0000);
        chk(rd, 32'h6342_2100, "select low reset");
        apb(1'b0, OFS_SEL_HIGH, 32'h0000_0000);
        chk(rd, 32'hE7C6_A584, "select high reset");
        for (int v = 1; v >= 0; v--) begin
            drive_src(CLK_GRP_LINE, 3'h7, 3'h7, v[0]);
            repeat (6) @(posedge core_clk);
            chk(ref_clk[7], v[0], "port 8 default clock");
            chk(sync_ref[7], v[0], "port 8 default sync");
        end
        // Unmapped address answers with an error and zero data
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        $display("test reset and refusals done");
        // Every clock code once, spread over all eight ports and both registers
        for (int c = 0; c < 32; c++) begin
            p = (c * 3) % 8;
            code = 5'(c);
            s = code[2:0] ^ 3'h5;      // Sync code decoupled from the clock index
            apb(1'b1, (p < 4) ? OFS_SEL_LOW : OFS_SEL_HIGH, {24'h0, s, code} << (8 * (p % 4)));
            for (int v = 1; v >= 0; v--) begin
                drive_src(code[4:3], code[2:0], s, v[0]);
                repeat (6) @(posedge core_clk);
                chk(ref_clk[p], v[0], "selected clock");
                chk(sync_ref[p], v[0], "selected sync");
            end
        end
        $display("test source codes done");
        // External mode: fields ignored, port 1 keeps its own sources
        apb(1'b1, OFS_MODE_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_SEL_LOW, 32'h0000_00F3);
        for (int v = 1; v >= 0; v--) begin
            drive_src(CLK_GRP_LINE, 3'h0, 3'h0, v[0]);
            repeat (6) @(posedge core_clk);
            chk(ref_clk[0], v[0], "external mode clock");
            chk(sync_ref[0], v[0], "external mode sync");
        end
        $display("test external mode done");
        stop_test();
    end
endmodule
